// File: hw/frame_observer.sv
// registers an observed network frame and classifies its station
`timescale 1ns/1ps
`default_nettype none

module frame_observer
    import port_tables_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // own station configuration
    input wire logic [5:0] i_own_station,
    input wire logic [2:0] i_virtual_count,
    // observed frame
    input wire logic i_frame_valid,
    input wire logic i_frame_is_response,
    input wire logic [5:0] i_frame_station,
    input wire logic [31:0] i_frame_data,
    // classified frame
    output logic o_valid,
    output logic o_response,
    output logic [5:0] o_station,
    output logic [31:0] o_data,
    output logic o_own,
    output logic o_mark
);

    frame_s cur_ff;
    frame_s nxt_ff;

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.valid = i_frame_valid;
        if (i_frame_valid) begin
            nxt_ff.response = i_frame_is_response;
            nxt_ff.station = i_frame_station;
            nxt_ff.data = i_frame_data;
            nxt_ff.own = in_own_range(i_frame_station, i_own_station, i_virtual_count);
            // own range counts as seen by request, others by response
            nxt_ff.mark = nxt_ff.own ? !i_frame_is_response : i_frame_is_response;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign o_valid = cur_ff.valid;
    assign o_response = cur_ff.response;
    assign o_station = cur_ff.station;
    assign o_data = cur_ff.data;
    assign o_own = cur_ff.own;
    assign o_mark = cur_ff.mark;

endmodule : frame_observer

`default_nettype wire

// File: hw/network_port_image_tables.sv
// port data, change enable, change flag and connection tables of the network port
`timescale 1ns/1ps
`default_nettype none

module network_port_image_tables
    import port_tables_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // host table access
    input wire logic [1:0] i_host_table,
    input wire logic [7:0] i_host_addr,
    input wire logic i_host_rd,
    input wire logic i_host_wr,
    input wire logic [7:0] i_host_wdata,
    output logic [7:0] o_host_rdata,
    output logic o_host_rvalid,
    // own station configuration
    input wire logic [5:0] i_own_station,
    input wire logic [2:0] i_virtual_count,
    input wire logic [3:0] i_own_input_mask,
    // observed network frames
    input wire logic i_frame_valid,
    input wire logic i_frame_is_response,
    input wire logic [5:0] i_frame_station,
    input wire logic [31:0] i_frame_data,
    // status
    output logic [15:0] o_status_word,
    output logic o_change_event_flag
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_ff[1];

    // ------------------------------------------------------------
    // frame capture
    // ------------------------------------------------------------
    logic f_valid;
    logic f_response;
    logic [5:0] f_station;
    logic [31:0] f_data;
    logic f_own;
    logic f_mark;

    frame_observer u_frame_observer (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .i_own_station(i_own_station),
        .i_virtual_count(i_virtual_count),
        .i_frame_valid(i_frame_valid),
        .i_frame_is_response(i_frame_is_response),
        .i_frame_station(i_frame_station),
        .i_frame_data(i_frame_data),
        .o_valid(f_valid),
        .o_response(f_response),
        .o_station(f_station),
        .o_data(f_data),
        .o_own(f_own),
        .o_mark(f_mark)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // lowest set station, or the no-station code when none is set
    function automatic logic [6:0] lowest_station(input logic [`PT_STATIONS-1:0] v);
        logic [6:0] r;
        r = `PT_NO_STATION;
        for (int i = `PT_STATIONS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 7'(i);
            end
        end
        return r;
    endfunction : lowest_station

    // table byte or bit index of a station port
    function automatic logic [7:0] port_index(input logic [5:0] st, input logic [1:0] p);
        return {st, p};
    endfunction : port_index

    // station that a port data byte address belongs to
    function automatic logic [5:0] station_of(input logic [7:0] a);
        return a[7:2];
    endfunction : station_of

    // first bit of an enable or flag map byte
    function automatic logic [7:0] map_base(input logic [7:0] a);
        return {a[4:0], 3'h0};
    endfunction : map_base

    // first bit of a connection map byte
    function automatic logic [5:0] conn_base(input logic [7:0] a);
        return {a[2:0], 3'h0};
    endfunction : conn_base

    // a frame byte is stored for remote responses and own outputs of requests
    function automatic logic takes_byte(input logic own, input logic response, input logic is_input);
        logic keep;
        keep = 1'b0;
        if (own) begin
            // inputs of the own range are never written by the network
            keep = !response && !is_input;
        end else begin
            keep = response;
        end
        return keep;
    endfunction : takes_byte

    // an enabled port raises its flag on any differing bit
    function automatic logic raises_flag(input logic [7:0] fresh, input logic [7:0] old, input logic en);
        return en && (fresh != old);
    endfunction : raises_flag

    // flag byte after a host write: ones clear, zeros keep
    function automatic logic [7:0] cleared_flags(input logic [7:0] old, input logic [7:0] w);
        return old & ~w;
    endfunction : cleared_flags

    // station whose response refreshes the connection map
    function automatic logic [6:0] refresh_station(input logic [`PT_STATIONS-1:0] conn,
        input logic [`PT_STATIONS-1:0] seen);
        logic [6:0] r;
        r = lowest_station(conn);
        // nothing connected yet: the lowest seen station takes its place
        if (r == `PT_NO_STATION) begin
            r = lowest_station(seen);
        end
        return r;
    endfunction : refresh_station

    // status word with only the change event bit in use
    function automatic logic [15:0] status_of(input logic [`PT_BYTES-1:0] flags);
        logic [15:0] s;
        s = 16'h0000;
        s[`PT_STATUS_CHANGE_BIT] = |flags;
        return s;
    endfunction : status_of

    // ------------------------------------------------------------
    // table state
    // ------------------------------------------------------------
    tables_s cur_ff;
    tables_s nxt_ff;
    table_sel_e host_sel;
    logic host_own;
    logic [6:0] ref_station;
    logic refresh;
    logic [7:0] idx;
    logic [7:0] new_byte;
    logic port_input;
    logic take;
    logic [7:0] old_byte;

    // ------------------------------------------------------------
    // host decode
    // ------------------------------------------------------------
    assign host_sel = table_sel_e'(i_host_table);
    assign host_own = in_own_range(station_of(i_host_addr), i_own_station, i_virtual_count);

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.rvalid = 1'b0;
        idx = 8'h00;
        new_byte = 8'h00;
        port_input = 1'b0;
        take = 1'b0;
        old_byte = 8'h00;
        ref_station = 7'h00;
        refresh = 1'b0;

        // --------------------------------------------------------
        // host read, answered one cycle later
        // --------------------------------------------------------
        if (i_host_rd) begin
            nxt_ff.rvalid = 1'b1;
            nxt_ff.rdata = 8'h00;
            unique case (host_sel)
                TABLE_PORT_DATA: begin
                    if (i_host_addr <= `PT_DATA_LAST) begin
                        nxt_ff.rdata = cur_ff.port_data[i_host_addr];
                    end
                end
                TABLE_CHANGE_ENABLE: begin
                    if (i_host_addr <= `PT_MAP_LAST) begin
                        nxt_ff.rdata = cur_ff.enable[map_base(i_host_addr) +: 8];
                    end
                end
                TABLE_CHANGE_FLAG: begin
                    if (i_host_addr <= `PT_MAP_LAST) begin
                        nxt_ff.rdata = cur_ff.flag[map_base(i_host_addr) +: 8];
                    end
                end
                TABLE_CONNECTION: begin
                    if (i_host_addr <= `PT_CONN_LAST) begin
                        nxt_ff.rdata = cur_ff.conn[conn_base(i_host_addr) +: 8];
                    end
                end
            endcase
        end

        // --------------------------------------------------------
        // host write
        // --------------------------------------------------------
        if (i_host_wr) begin
            unique case (host_sel)
                TABLE_PORT_DATA: begin
                    // only own and virtual station bytes take host data
                    if (host_own) begin
                        nxt_ff.port_data[i_host_addr] = i_host_wdata;
                    end
                end
                TABLE_CHANGE_ENABLE: begin
                    if (i_host_addr <= `PT_MAP_LAST) begin
                        nxt_ff.enable[map_base(i_host_addr) +: 8] = i_host_wdata;
                    end
                end
                TABLE_CHANGE_FLAG: begin
                    if (i_host_addr <= `PT_MAP_LAST) begin
                        nxt_ff.flag[map_base(i_host_addr) +: 8] =
                            cleared_flags(cur_ff.flag[map_base(i_host_addr) +: 8], i_host_wdata);
                    end
                end
                TABLE_CONNECTION: begin
                end
            endcase
        end

        // --------------------------------------------------------
        // frame data and change detection; flag set wins over a clear
        // --------------------------------------------------------
        if (f_valid) begin
            for (int p = 0; p < `PT_PORTS; p++) begin
                idx = port_index(f_station, 2'(p));
                new_byte = f_data[p*8 +: 8];
                old_byte = cur_ff.port_data[idx];
                port_input = f_own && i_own_input_mask[p];
                take = takes_byte(f_own, f_response, port_input);
                if (take) begin
                    nxt_ff.port_data[idx] = new_byte;
                    // any differing bit counts, not only bit 0
                    if (raises_flag(new_byte, old_byte, cur_ff.enable[idx])) begin
                        nxt_ff.flag[idx] = 1'b1;
                    end
                end
            end
        end

        // --------------------------------------------------------
        // connection map refresh
        // --------------------------------------------------------
        if (f_valid) begin
            ref_station = refresh_station(cur_ff.conn, cur_ff.seen);
            refresh = f_response && (ref_station == {1'b0, f_station});
            if (refresh) begin
                nxt_ff.conn = cur_ff.seen;
                nxt_ff.seen = '0;
            end
            if (f_mark) begin
                nxt_ff.seen[f_station] = 1'b1;
                if (refresh) begin
                    nxt_ff.conn[f_station] = 1'b1;
                end
            end
        end

        // --------------------------------------------------------
        // status word follows the flags as they will be stored
        // --------------------------------------------------------
        nxt_ff.status = status_of(nxt_ff.flag);
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_host_rdata = cur_ff.rdata;
    assign o_host_rvalid = cur_ff.rvalid;
    assign o_status_word = cur_ff.status;
    assign o_change_event_flag = cur_ff.status[`PT_STATUS_CHANGE_BIT];

endmodule : network_port_image_tables

`default_nettype wire

// File: hw/port_tables_params.svh
// constants for the network port image tables
// Contract
// - data table: reads remote, writes own only
// - data table bytes 0..255, station*4+port
// - four bytes per station, 64 stations
// - own input ports never raise change events
// - enable map bytes 0..31, two stations each
// - low nibble even station, high nibble odd
// - any bit change of port raises event
// - flags readable, write one clears flag
// - flag map placed exactly like enable map
// - own and virtual stations seen by requests
// - other stations seen by response frames
// - refresh on lowest connected station response
// - refresh sets seen stations, clears unseen
// - connection map bytes 0..7, bit per station
// - any flag sets status word bit 3
`ifndef PORT_TABLES_PARAMS_SVH
`define PORT_TABLES_PARAMS_SVH

`define PT_STATIONS 64
`define PT_PORTS 4
`define PT_BYTES 256
`define PT_DATA_LAST 8'hFF
`define PT_MAP_LAST 8'h1F
`define PT_CONN_LAST 8'h07
`define PT_STATUS_CHANGE_BIT 3
`define PT_DATA_RESET 8'h00
`define PT_NO_STATION 7'h40

`endif

// File: hw/port_tables_pkg.sv
// types and shared decoding for the network port image tables
`include "port_tables_params.svh"

package port_tables_pkg;

    typedef enum logic [1:0] {
        TABLE_PORT_DATA,
        TABLE_CHANGE_ENABLE,
        TABLE_CHANGE_FLAG,
        TABLE_CONNECTION
    } table_sel_e;

    typedef logic [5:0] station_t;

    typedef struct packed {
        logic [`PT_BYTES-1:0][7:0] port_data;
        logic [`PT_BYTES-1:0] enable;
        logic [`PT_BYTES-1:0] flag;
        logic [`PT_STATIONS-1:0] conn;
        logic [`PT_STATIONS-1:0] seen;
        logic [7:0] rdata;
        logic rvalid;
        logic [15:0] status;
    } tables_s;

    typedef struct packed {
        logic valid;
        logic response;
        station_t station;
        logic [31:0] data;
        logic own;
        logic mark;
    } frame_s;

    // station lies within own station plus its virtual stations
    function automatic logic in_own_range(input station_t st, input station_t own, input logic [2:0] vcount);
        station_t d;
        d = st - own;
        return d <= {3'h0, vcount};
    endfunction : in_own_range

endpackage : port_tables_pkg

// File: testbench/host_cpu_model.sv
// host processor model driving the table access port
`timescale 1ns/1ps
`default_nettype none

module host_cpu_model (
    // clock
    input wire logic i_clock,
    // table access
    output logic [1:0] o_table,
    output logic [7:0] o_addr,
    output logic o_rd,
    output logic o_wr,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid
);
    initial begin
        o_table = 2'h0;
        o_addr = 8'h00;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 8'h00;
    end

    task automatic wr(input logic [1:0] t, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        #1;
        o_table = t;
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_clock);
        #1;
        o_wr = 1'b0;
        // released data must not keep its last value
        o_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [1:0] t, input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge i_clock);
        #1;
        o_table = t;
        o_addr = a;
        o_rd = 1'b1;
        @(posedge i_clock);
        #1;
        o_rd = 1'b0;
        ok = i_rvalid;
        d = i_rdata;
    endtask : rd
endmodule : host_cpu_model

`default_nettype wire

// File: testbench/network_port_image_tables_properties.sv
// concurrent checks on the port image tables top ports
`timescale 1ns/1ps
`default_nettype none

module network_port_image_tables_checker (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // host access
    input wire logic [1:0] i_host_table,
    input wire logic [7:0] i_host_addr,
    input wire logic i_host_rd,
    input wire logic i_host_wr,
    input wire logic [7:0] o_host_rdata,
    input wire logic o_host_rvalid,
    // frames and status
    input wire logic i_frame_valid,
    input wire logic [15:0] o_status_word,
    input wire logic o_change_event_flag
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_arst_n);

    AST_RVALID: assert property (i_host_rd |=> o_host_rvalid)
        else $error("read not answered");
    AST_RVALID_ONLY: assert property (!i_host_rd |=> !o_host_rvalid)
        else $error("answer without a read");
    AST_RDATA_HOLD: assert property (!i_host_rd |=> $stable(o_host_rdata))
        else $error("read byte moved without a read");
    AST_MAP_RANGE: assert property (
        i_host_rd && i_host_table inside {2'h1, 2'h2} && i_host_addr > 8'h1F |=> o_host_rdata == 8'h00)
        else $error("map read beyond byte 31 not zero");
    AST_CONN_RANGE: assert property (
        i_host_rd && i_host_table == 2'h3 && i_host_addr > 8'h07 |=> o_host_rdata == 8'h00)
        else $error("connection read beyond byte 7 not zero");
    AST_STATUS_BITS: assert property (o_status_word[15:4] == 12'h000 && o_status_word[2:0] == 3'h0)
        else $error("unused status bits set");
    AST_EVENT_COPY: assert property (o_change_event_flag == o_status_word[3])
        else $error("event output differs from status bit");
    AST_EVENT_STICKY: assert property (
        o_change_event_flag && !i_host_wr && !$past(i_host_wr) |=> o_change_event_flag)
        else $error("event dropped without a write");
    AST_FLAG_CLEAR: assert property ($fell(o_change_event_flag) |->
        ($past(i_host_wr) && $past(i_host_table) == 2'h2) || ($past(i_host_wr, 2) && $past(i_host_table, 2) == 2'h2))
        else $error("event cleared without a flag write");
    AST_FLAG_CAUSE: assert property ($rose(o_change_event_flag) |->
        $past(i_frame_valid, 2) || $past(i_frame_valid, 3))
        else $error("event raised without a frame");
endmodule : network_port_image_tables_checker

bind network_port_image_tables network_port_image_tables_checker checker_u (.i_clock, .i_arst_n, .i_host_table,
    .i_host_addr, .i_host_rd, .i_host_wr, .o_host_rdata, .o_host_rvalid, .i_frame_valid, .o_status_word,
    .o_change_event_flag);

`default_nettype wire

// File: testbench/network_port_image_tables_tb_top.sv
// self-checking bench for the network port image tables
`timescale 1ns/1ps
`default_nettype none

module network_port_image_tables_tb_top;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] tsel;
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] in_mask = 4'h0;
    logic f_valid = 1'b0;
    logic f_resp = 1'b0;
    logic [5:0] f_station = 6'h00;
    logic [31:0] f_data = 32'h0;
    logic [15:0] status_word;
    logic event_flag;
    int err_total = 0;
    int cmp_count = 0;

    always #2.5 clock = ~clock;

    network_port_image_tables dut_u (.i_clock(clock), .i_arst_n(arst_n), .i_host_table(tsel), .i_host_addr(addr),
        .i_host_rd(rd), .i_host_wr(wr), .i_host_wdata(wdata), .o_host_rdata(rdata), .o_host_rvalid(rvalid),
        .i_own_station(6'h02), .i_virtual_count(3'h1), .i_own_input_mask(in_mask), .i_frame_valid(f_valid),
        .i_frame_is_response(f_resp), .i_frame_station(f_station), .i_frame_data(f_data),
        .o_status_word(status_word), .o_change_event_flag(event_flag));

    host_cpu_model host_u (.i_clock(clock), .o_table(tsel), .o_addr(addr), .o_rd(rd), .o_wr(wr),
        .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid));

    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic rdc(input string nm, input logic [1:0] t, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host_u.rd(t, a, d, ok);
        chk("rvalid", 8'h01, {7'h00, ok});
        chk(nm, exp, d);
    endtask : rdc

    task automatic frame(input logic r, input logic [5:0] s, input logic [31:0] d);
        @(posedge clock);
        #1;
        f_valid = 1'b1;
        f_resp = r;
        f_station = s;
        f_data = d;
        @(posedge clock);
        #1;
        f_valid = 1'b0;
        f_data = ~d;
        repeat (2) @(posedge clock);
    endtask : frame

    task automatic t_conn;
        frame(1'b1, 6'h09, 32'h0);
        frame(1'b1, 6'h0C, 32'h0);
        frame(1'b1, 6'h09, 32'h0);
        rdc("conn1", 2'h3, 8'h01, 8'h12);
        rdc("conn0", 2'h3, 8'h00, 8'h00);
        rdc("conn8", 2'h3, 8'h08, 8'h00);
        frame(1'b1, 6'h09, 32'h0);
        rdc("conn1", 2'h3, 8'h01, 8'h02);
        $display("test conn done");
    endtask : t_conn

    task automatic t_remote;
        frame(1'b1, 6'h05, 32'h44332211);
        for (int i = 0; i < 4; i++) begin
            rdc("data", 2'h0, 8'(20 + i), 8'(8'h11 * (i + 1)));
        end
        frame(1'b1, 6'h3F, 32'hDDCCBBAA);
        rdc("data255", 2'h0, 8'hFF, 8'hDD);
        frame(1'b1, 6'h02, 32'hFFFFFFFF);
        rdc("own8", 2'h0, 8'h08, 8'h00);
        $display("test remote done");
    endtask : t_remote

    task automatic t_own;
        host_u.wr(2'h0, 8'h08, 8'hA5);
        rdc("own8", 2'h0, 8'h08, 8'hA5);
        host_u.wr(2'h0, 8'h0C, 8'h3C);
        rdc("virt12", 2'h0, 8'h0C, 8'h3C);
        host_u.wr(2'h0, 8'h28, 8'h5A);
        rdc("remote40", 2'h0, 8'h28, 8'h00);
        $display("test own done");
    endtask : t_own

    task automatic t_flag;
        host_u.wr(2'h1, 8'h02, 8'h12);
        host_u.wr(2'h1, 8'h20, 8'hFF);
        rdc("en2", 2'h1, 8'h02, 8'h12);
        rdc("en32", 2'h1, 8'h20, 8'h00);
        frame(1'b1, 6'h04, 32'h00000100);
        rdc("flag2", 2'h2, 8'h02, 8'h02);
        frame(1'b1, 6'h05, 32'h44334491);
        rdc("flag2", 2'h2, 8'h02, 8'h12);
        chk("event", 8'h01, {7'h00, event_flag});
        chk("status", 8'h08, status_word[7:0]);
        chk("status_hi", 8'h00, status_word[15:8]);
        host_u.wr(2'h2, 8'h02, 8'hED);
        rdc("flag2", 2'h2, 8'h02, 8'h12);
        host_u.wr(2'h2, 8'h02, 8'h12);
        rdc("flag2", 2'h2, 8'h02, 8'h00);
        chk("event", 8'h00, {7'h00, event_flag});
        chk("status", 8'h00, status_word[7:0]);
        $display("test flag done");
    endtask : t_flag

    task automatic t_input;
        @(posedge clock);
        #1;
        in_mask = 4'h1;
        host_u.wr(2'h1, 8'h01, 8'h0F);
        frame(1'b0, 6'h02, 32'h000077CC);
        rdc("flag1", 2'h2, 8'h01, 8'h02);
        rdc("own8", 2'h0, 8'h08, 8'hA5);
        rdc("own9", 2'h0, 8'h09, 8'h77);
        $display("test input done");
    endtask : t_input

    initial begin
        #100000;
        err_total++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge clock);
        #1;
        arst_n = 1'b1;
        repeat (3) @(posedge clock);
        rdc("reset", 2'h0, 8'h10, 8'h00);
        t_conn();
        t_remote();
        t_own();
        t_flag();
        t_input();
        close_out();
    end
endmodule : network_port_image_tables_tb_top

`default_nettype wire
